// >>> hw/uelm_pkg.sv
// Purpose: constants and types for the uplink extended message receiver
// Assumes: decoded interrogation fields arrive from a frame decoder on pclk
// Notes:   register map is reached over apb
//
// Functional notes
// RULE_01: up to sixteen segments, uplink format 24
// RULE_02: code 0 clears storage, no reply
// RULE_03: initial segment is last, sets length
// RULE_04: new initial segment abandons earlier message
// RULE_05: without initialisation, later segments are discarded
// RULE_06: code 1 stores and marks, no reply
// RULE_07: code 2 stores, replies format 24 acknowledged
// RULE_08: bitmap bit per segment, cumulative since start
// RULE_09: ground repeats final segment until acknowledged
// RULE_10: ground resends missing segments, then final
// RULE_11: ground spaces segments at least 50 us
// RULE_12: ground always sends at least two segments
// RULE_13: full message handed out once complete
// RULE_14: closeout code 5 ends non-selective delivery
// RULE_15: ground reserves with di 1 mes 1 rss 2
// RULE_16: reservation reply reports holder site address
// RULE_17: ground delivers only when reservation is its own
// RULE_18: multisite closeout accepted only from holder; code also accepts it from any site while no reservation is held
// RULE_19: eighteen second inactivity cancels and discards; code freezes the timer while a complete message is held
// RULE_20: grant only when free or already held
package uelm_pkg;
	// ************************************************************
	// link field codes
	// ************************************************************
	localparam int          SEG_MAX     = 16;
	localparam logic [4:0]  UF_COMMC    = 5'h18;
	localparam logic [4:0]  DF_COMMD    = 5'h18;
	localparam logic [1:0]  RC_INIT     = 2'h0;
	localparam logic [1:0]  RC_INTER    = 2'h1;
	localparam logic [1:0]  RC_FINAL    = 2'h2;
	localparam logic [2:0]  PC_UCLOSE   = 3'h5;
	localparam logic [2:0]  DI_MULTI    = 3'h1;
	localparam logic [2:0]  MES_RESERVE = 3'h1;
	localparam logic [2:0]  MES_CLOSE   = 3'h2;
	localparam logic [1:0]  RSS_UPLINK  = 2'h2;
	localparam logic        KE_ACK      = 1'h1;
	// ************************************************************
	// timing
	// ************************************************************
	localparam longint      CLK_HZ      = 125_000_000;
	localparam longint      TIMEOUT_S   = 18;
	localparam longint      TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [11:0] REG_STATUS  = 12'h000;
	localparam logic [11:0] REG_BITMAP  = 12'h004;
	localparam logic [11:0] REG_RESV    = 12'h008;
	localparam logic [11:0] REG_CTRL    = 12'h00c;
	localparam logic [11:0] REG_MSGSEL  = 12'h010;
	localparam logic [11:0] REG_MSGDATA = 12'h014;
	localparam logic [11:0] REG_MSGDHI  = 12'h018;
	localparam int          ST_ACTIVE   = 0;
	localparam int          ST_READY    = 1;
	localparam int          ST_RESV     = 2;
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_REL    = 1;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
	localparam logic [31:0] SLV_ERRDATA = 32'h0000_0000;
endpackage : uelm_pkg

// >>> hw/uelm_rx.sv
`timescale 1ns/1ns
// Purpose: reassembles uplink extended messages and manages the uplink reservation
// Assumes: frame decoder gives one cycle pulses with decoded fields on pclk
// Notes:   reply request is a one cycle pulse; the encoder sends it
module uelm_rx #(
	parameter longint TIMEOUT_CYC = uelm_pkg::TIMEOUT_CYC
) (
	input  wire logic        pclk,         // system clock
	input  wire logic        presetn,      // async reset, low
	input  wire logic [11:0] paddr,        // apb address
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb enable
	input  wire logic        pwrite,       // apb direction
	input  wire logic [31:0] pwdata,       // apb write data
	output logic      [31:0] prdata,       // apb read data
	output logic             pready,       // apb ready
	output logic             pslverr,      // apb error
	input  wire logic        ic_valid,     // comm-c interrogation pulse
	input  wire logic [4:0]  ic_uf,        // uplink format
	input  wire logic [1:0]  ic_rc,        // reply control
	input  wire logic [3:0]  ic_nc,        // segment number
	input  wire logic [55:0] ic_mc,        // segment text
	input  wire logic        is_valid,     // surveillance or comm-a pulse
	input  wire logic [2:0]  is_pc,        // protocol field
	input  wire logic [2:0]  is_di,        // designator
	input  wire logic [3:0]  is_iis,       // site address
	input  wire logic [2:0]  is_mes,       // multisite message subfield
	input  wire logic [1:0]  is_rss,       // reservation status request
	output logic             ack_valid,    // comm-d reply request pulse
	output logic      [4:0]  ack_df,       // reply format
	output logic             ack_ke,       // control, ele
	output logic      [15:0] ack_tas,      // acknowledgement bitmap
	output logic             um_valid,     // reservation report pulse
	output logic      [3:0]  um_iis,       // reported holder
	output logic             msg_ready,    // complete message held
	output logic      [3:0]  msg_last      // highest segment number
);
	// ************************************************************
	// state
	// ************************************************************
	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_ASSM  = 3'b010,
		S_DONE  = 3'b100
	} uelm_state_type;

	localparam logic [31:0] CTRL_MASK = 32'h0000_0003; // writable control bits

	uelm_state_type state_q;
	logic [15:0]    bits_q;
	logic [3:0]     last_q;
	logic           resv_q;
	logic [3:0]     resv_iis_q;
	logic [34:0]    tmr_q;
	logic [31:0]    ctrl_q;
	logic [3:0]     sel_q;
	logic           tmr_kick;
	logic           expire;
	logic           close_ok;
	logic           is_commc;
	logic           reserve_req;
	logic           take_seg;
	logic [15:0]    bits_next;
	logic           enable;
	logic           apb_setup;
	logic           apb_wr;
	uelm_seg_if     seg ();

	uelm_seg_store #(.DEPTH(uelm_pkg::SEG_MAX)) i_uelm_seg_store (
		.pclk (pclk),
		.seg  (seg)
	);

	function automatic logic [15:0] upto_mask(input logic [3:0] last);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < uelm_pkg::SEG_MAX; i++)
			m[i] = (i <= int'(last));
		return m;
	endfunction : upto_mask

	// one decode for every write strobe, so all of them land on the same edge
	function automatic logic wr_hit(input logic [11:0] off);
		return apb_wr && (paddr == off);
	endfunction : wr_hit

	assign enable      = ctrl_q[uelm_pkg::CTRL_EN];
	// writes land on the access edge that completes the transfer
	assign apb_setup   = psel && !penable;
	assign apb_wr      = psel && penable && pready && pwrite;
	assign is_commc    = ic_valid && enable && (ic_uf == uelm_pkg::UF_COMMC); // RULE_01
	assign reserve_req = is_valid && enable && (is_di == uelm_pkg::DI_MULTI) &&
	                     (is_mes == uelm_pkg::MES_RESERVE);
	// accept multisite closeout from holder only; a free link also accepts it
	assign close_ok    = is_valid && enable &&
	                     ((is_pc == uelm_pkg::PC_UCLOSE) || // RULE_14
	                      ((is_di == uelm_pkg::DI_MULTI) && (is_mes == uelm_pkg::MES_CLOSE) &&
	                       (!resv_q || (is_iis == resv_iis_q)))); // RULE_18
	// segments other than code 0 only count after initialisation
	assign take_seg    = is_commc && ((ic_rc == uelm_pkg::RC_INIT) ||
	                     (state_q != S_IDLE && (ic_rc == uelm_pkg::RC_INTER || ic_rc == uelm_pkg::RC_FINAL))); // RULE_05
	assign tmr_kick    = reserve_req || (take_seg && state_q != S_IDLE) || (is_commc && ic_rc == uelm_pkg::RC_INIT);
	assign expire      = (tmr_q == 35'(1));

	// store every accepted segment; only the bitmap says which entries are valid
	assign seg.wr_en   = take_seg; // RULE_06
	assign seg.wr_idx  = ic_nc;
	assign seg.wr_data = ic_mc;
	assign seg.rd_sel  = sel_q;

	always_comb
	begin
		bits_next = bits_q;
		if (take_seg)
		begin
			if (ic_rc == uelm_pkg::RC_INIT)
				bits_next = 16'h0001 << ic_nc; // RULE_02 RULE_03 RULE_04
			else
				bits_next = bits_q | (16'h0001 << ic_nc); // RULE_08
		end
	end

	// ************************************************************
	// reassembly
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= S_IDLE;
			bits_q  <= 16'h0000;
		end
		else if (expire || close_ok)
		begin
			state_q <= S_IDLE; // RULE_19
			bits_q  <= 16'h0000;
		end
		else if (take_seg)
		begin
			bits_q <= bits_next;
			if (ic_rc == uelm_pkg::RC_INIT)
			begin
				state_q <= S_ASSM; // RULE_04
			end
			else if ((bits_next & upto_mask(last_q)) == upto_mask(last_q))
				state_q <= S_DONE; // RULE_13
		end
		// release needs the bit in the written word, not the stored one
		else if (state_q == S_DONE && wr_hit(uelm_pkg::REG_CTRL) && pwdata[uelm_pkg::CTRL_REL])
			state_q <= S_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_q <= 4'h0;
		else if (take_seg && ic_rc == uelm_pkg::RC_INIT && !(expire || close_ok))
			last_q <= ic_nc; // RULE_03
	end

	// ************************************************************
	// replies
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_valid <= 1'b0;
			ack_df    <= 5'h00;
			ack_ke    <= 1'b0;
			ack_tas   <= 16'h0000;
		end
		else
		begin
			// code 0 and code 1 never raise a reply
			ack_valid <= take_seg && (ic_rc == uelm_pkg::RC_FINAL); // RULE_07
			if (take_seg && ic_rc == uelm_pkg::RC_FINAL)
			begin
				ack_df  <= uelm_pkg::DF_COMMD; // RULE_07
				ack_ke  <= uelm_pkg::KE_ACK;
				ack_tas <= bits_next; // RULE_08
			end
		end
	end

	// ************************************************************
	// reservation and timer
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resv_q     <= 1'b0;
			resv_iis_q <= 4'h0;
		end
		else if (expire || close_ok)
		begin
			resv_q     <= 1'b0; // RULE_19
			resv_iis_q <= 4'h0;
		end
		else if (reserve_req && (!resv_q || resv_iis_q == is_iis))
		begin
			resv_q     <= 1'b1; // RULE_20
			resv_iis_q <= is_iis;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			um_valid <= 1'b0;
			um_iis   <= 4'h0;
		end
		else
		begin
			um_valid <= reserve_req && (is_rss == uelm_pkg::RSS_UPLINK);
			// a refused request reports the current holder, not the requester
			if (reserve_req)
				um_iis <= (!resv_q || resv_iis_q == is_iis) ? is_iis : resv_iis_q; // RULE_16
		end
	end

	// zero means idle; a kick loads the full span
	// frozen once complete, so a held message keeps its reservation
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tmr_q <= 35'h0;
		else if (close_ok || expire)
			tmr_q <= 35'h0;
		else if (tmr_kick)
			tmr_q <= 35'(TIMEOUT_CYC); // RULE_19
		else if (tmr_q != 35'h0 && state_q != S_DONE)
			tmr_q <= tmr_q - 35'(1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			msg_ready <= 1'b0;
			msg_last  <= 4'h0;
		end
		else
		begin
			msg_ready <= (state_q == S_DONE); // RULE_13
			msg_last  <= last_q;
		end
	end

	// ************************************************************
	// apb slave, zero wait states
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		// only the two control bits are kept; the rest read back as zero
		if (!presetn)
			ctrl_q <= uelm_pkg::CTRL_RESET;
		else if (wr_hit(uelm_pkg::REG_CTRL))
			ctrl_q <= pwdata & CTRL_MASK;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sel_q <= 4'h0;
		else if (wr_hit(uelm_pkg::REG_MSGSEL))
			sel_q <= pwdata[3:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= apb_setup;
			pslverr <= 1'b0;
			if (apb_setup)
			begin
				unique case (paddr)
					uelm_pkg::REG_STATUS:  prdata <= {29'h0, resv_q, state_q == S_DONE, state_q != S_IDLE};
					uelm_pkg::REG_BITMAP:  prdata <= {16'h0000, bits_q};
					uelm_pkg::REG_RESV:    prdata <= {24'h0, last_q, resv_iis_q};
					uelm_pkg::REG_CTRL:    prdata <= ctrl_q;
					uelm_pkg::REG_MSGSEL:  prdata <= {28'h0, sel_q};
					uelm_pkg::REG_MSGDATA: prdata <= seg.rd_data[31:0];
					uelm_pkg::REG_MSGDHI:  prdata <= {8'h00, seg.rd_data[55:32]};
					default:
					begin
						prdata  <= uelm_pkg::SLV_ERRDATA;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule : uelm_rx

// >>> hw/uelm_seg_if.sv
`timescale 1ns/1ns
// Purpose: carries one decoded segment write into the segment store
// Assumes: single pclk domain
// Notes:   read port is combinational on rd_sel
interface uelm_seg_if;
	logic        wr_en;    // store one segment
	logic [3:0]  wr_idx;   // segment number
	logic [55:0] wr_data;  // segment text
	logic [3:0]  rd_sel;   // read selection
	logic [55:0] rd_data;  // selected text
	modport ctl (output wr_en, wr_idx, wr_data, rd_sel, input rd_data);
	modport mem (input wr_en, wr_idx, wr_data, rd_sel, output rd_data);
endinterface : uelm_seg_if

// >>> hw/uelm_seg_store.sv
`timescale 1ns/1ns
// Purpose: sixteen entry segment text store
// Assumes: bookkeeping of valid entries is held by the controller
// Notes:   contents are not reset; validity comes from the bitmap only
module uelm_seg_store #(
	parameter int DEPTH = 16
) (
	input  wire logic   pclk,  // system clock
	uelm_seg_if.mem     seg    // write and read port
);
	logic [55:0] mem_q [DEPTH];

	always_ff @(posedge pclk)
	begin
		if (seg.wr_en)
			mem_q[seg.wr_idx] <= seg.wr_data; // RULE_06
	end

	assign seg.rd_data = mem_q[seg.rd_sel];
endmodule : uelm_seg_store

// >>> verif/uelm_gnd.sv
// Purpose: ground interrogator model giving decoded fields
// Assumes: one interrogation per pulse
// Notes:   idle fields show the inverse of the last value
`timescale 1ns/1ns
module uelm_gnd #(
	parameter int GAP = 6250 // cycles between interrogations
) (
	input  wire logic   pclk,     // clock
	output logic        ic_valid, // segment
	output logic [4:0]  ic_uf,    // format
	output logic [1:0]  ic_rc,    // control
	output logic [3:0]  ic_nc,    // number
	output logic [55:0] ic_mc,    // text
	output logic        is_valid, // surveillance
	output logic [2:0]  is_pc,    // protocol
	output logic [2:0]  is_di,    // designator
	output logic [3:0]  is_iis,   // site
	output logic [2:0]  is_mes,   // subfield
	output logic [1:0]  is_rss    // request
);
	// ****
	// interrogations
	// ****
	initial {ic_valid, ic_uf, ic_rc, ic_nc, ic_mc, is_valid, is_pc, is_di, is_iis, is_mes, is_rss} = '0;
	task seg(input logic [4:0] uf, input logic [1:0] rc, input logic [3:0] nc, input logic [55:0] mc);
		@(posedge pclk);
		ic_valid <= 1'b1;
		{ic_uf, ic_rc, ic_nc, ic_mc} <= {uf, rc, nc, mc};
		@(posedge pclk);
		ic_valid <= 1'b0;
		{ic_uf, ic_rc, ic_nc, ic_mc} <= ~{uf, rc, nc, mc};
		repeat (GAP) @(posedge pclk);
	endtask : seg
	task surv(input logic [2:0] pc, input logic [2:0] di, input logic [2:0] mes, input logic [1:0] rss,
		input logic [3:0] iis);
		@(posedge pclk);
		is_valid <= 1'b1;
		{is_pc, is_di, is_mes, is_rss, is_iis} <= {pc, di, mes, rss, iis};
		@(posedge pclk);
		is_valid <= 1'b0;
		{is_pc, is_di, is_mes, is_rss, is_iis} <= ~{pc, di, mes, rss, iis};
		repeat (GAP) @(posedge pclk);
	endtask : surv
endmodule : uelm_gnd

// >>> verif/uelm_rx_chk.sv
// Purpose: port assertions for uelm_rx
// Assumes: no closeout is sent while the block is disabled and a message is held
// Notes:   ready lags the reply by one cycle
`timescale 1ns/1ns
module uelm_rx_chk (
	input wire logic        pclk,      // clock
	input wire logic        presetn,   // reset
	input wire logic        ic_valid,  // segment
	input wire logic [4:0]  ic_uf,     // format
	input wire logic [1:0]  ic_rc,     // control
	input wire logic [3:0]  ic_nc,     // number
	input wire logic        is_valid,  // surveillance
	input wire logic [2:0]  is_pc,     // protocol
	input wire logic [1:0]  is_rss,    // request
	input wire logic        ack_valid, // reply
	input wire logic [4:0]  ack_df,    // format
	input wire logic        ack_ke,    // control
	input wire logic [15:0] ack_tas,   // bitmap
	input wire logic        um_valid,  // report
	input wire logic        msg_ready, // held
	input wire logic [3:0]  msg_last   // length
);
	// ****
	// properties
	// ****
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ack_cause;
		ack_valid |-> $past(ic_valid) && $past(ic_rc) == uelm_pkg::RC_FINAL && $past(ic_uf) == uelm_pkg::UF_COMMC;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("reply without final");
	property p_ack_fmt;
		ack_valid |-> ack_df == uelm_pkg::DF_COMMD && ack_ke == uelm_pkg::KE_ACK;
	endproperty
	a_ack_fmt: assert property (p_ack_fmt) else $error("reply format");
	property p_quiet;
		ic_valid && ic_rc != uelm_pkg::RC_FINAL |=> !ack_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("reply to code 0 or 1");
	property p_uf;
		ic_valid && ic_uf != uelm_pkg::UF_COMMC |=> !ack_valid;
	endproperty
	a_uf: assert property (p_uf) else $error("reply to other format");
	property p_tas_own;
		ack_valid |-> ack_tas[$past(ic_nc)];
	endproperty
	a_tas_own: assert property (p_tas_own) else $error("final bit clear");
	property p_um;
		um_valid |-> $past(is_valid) && $past(is_rss) == uelm_pkg::RSS_UPLINK;
	endproperty
	a_um: assert property (p_um) else $error("report without request");
	property p_full;
		ack_valid && ({1'b0, ack_tas} + 17'h0_0001) == (17'h0_0001 << (msg_last + 5'h01)) |=> msg_ready;
	endproperty
	a_full: assert property (p_full) else $error("full message not ready");
	property p_init;
		ic_valid && ic_uf == uelm_pkg::UF_COMMC && ic_rc == uelm_pkg::RC_INIT |-> ##2 !msg_ready;
	endproperty
	a_init: assert property (p_init) else $error("ready after init");
	property p_close;
		is_valid && is_pc == uelm_pkg::PC_UCLOSE |-> ##2 !msg_ready;
	endproperty
	a_close: assert property (p_close) else $error("ready after closeout");
endmodule : uelm_rx_chk
bind uelm_rx uelm_rx_chk i_uelm_rx_chk (.pclk, .presetn, .ic_valid, .ic_uf, .ic_rc, .ic_nc, .is_valid, .is_pc,
	.is_rss, .ack_valid, .ack_df, .ack_ke, .ack_tas, .um_valid, .msg_ready, .msg_last);

// >>> verif/uelm_rx_tb.sv
// Purpose: self checking bench for uelm_rx
// Assumes: timer scaled to 1000 cycles
// Notes:   replies are compared in arrival order
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module uelm_rx_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        ic_valid, is_valid, ack_valid, ack_ke, um_valid, msg_ready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, seed = 32'h0000_5fea;
	logic [4:0]  ic_uf, ack_df;
	logic [1:0]  ic_rc, is_rss;
	logic [3:0]  ic_nc, is_iis, um_iis, msg_last, q_um[$], e_um;
	logic [2:0]  is_pc, is_di, is_mes;
	logic [55:0] ic_mc, mc, m2;
	logic [15:0] ack_tas, q_ack[$], e_ack;
	logic [32:0] q_rd[$], e_rd;
	int          n_errors = 0, compares = 0;
	uelm_rx #(.TIMEOUT_CYC(1000)) i_uelm_rx (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .ic_valid, .ic_uf, .ic_rc, .ic_nc, .ic_mc, .is_valid, .is_pc, .is_di, .is_iis, .is_mes,
		.is_rss, .ack_valid, .ack_df, .ack_ke, .ack_tas, .um_valid, .um_iis, .msg_ready, .msg_last);
	uelm_gnd #(.GAP(4)) i_uelm_gnd (.pclk, .ic_valid, .ic_uf, .ic_rc, .ic_nc, .ic_mc, .is_valid, .is_pc, .is_di,
		.is_iis, .is_mes, .is_rss);
	// ****
	// helpers
	// ****
	initial pclk = 1'b0;
	always #4 pclk = ~pclk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		{pwrite, paddr, pwdata} <= {w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (n == 50) n_errors++;
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask : apb
	task rd(input logic [11:0] a, input logic [32:0] e);
		q_rd.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	task s(input logic [1:0] rc, input logic [3:0] nc);
		r = xs();
		mc = {r[23:0], xs()};
		i_uelm_gnd.seg(uelm_pkg::UF_COMMC, rc, nc, mc);
	endtask : s
	task rsv(input logic [3:0] iis, input logic [3:0] e);
		q_um.push_back(e);
		r = xs();
		i_uelm_gnd.surv({1'b0, r[1:0]}, uelm_pkg::DI_MULTI, uelm_pkg::MES_RESERVE, uelm_pkg::RSS_UPLINK, iis);
	endtask : rsv
	task cls(input logic [3:0] iis);
		r = xs();
		i_uelm_gnd.surv({1'b0, r[3:2]}, uelm_pkg::DI_MULTI, uelm_pkg::MES_CLOSE, r[1:0], iis);
	endtask : cls
	task tally_and_finish();
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	// ****
	// monitor and sequence
	// ****
	always @(posedge pclk)
	begin
		if (ack_valid === 1'b1)
		begin
			e_ack = q_ack.size() ? q_ack.pop_front() : 'x;
			`CHK(ack_tas, e_ack)
			`CHK({ack_df, ack_ke}, {uelm_pkg::DF_COMMD, uelm_pkg::KE_ACK})
		end
		if (um_valid === 1'b1)
		begin
			e_um = q_um.size() ? q_um.pop_front() : 'x;
			`CHK(um_iis, e_um)
		end
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			e_rd = q_rd.size() ? q_rd.pop_front() : 'x;
			`CHK({pslverr, prdata}, e_rd)
		end
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		tally_and_finish();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(uelm_pkg::REG_STATUS, 33'h0_0000_0000);
		rd(uelm_pkg::REG_CTRL, {1'b0, uelm_pkg::CTRL_RESET});
		rd(12'h01c, 33'h1_0000_0000);
		// segments before any init must be dropped silently
		s(2'h1, 4'h1);
		s(2'h2, 4'h0);
		rd(uelm_pkg::REG_BITMAP, 33'h0_0000_0000);
		s(2'h0, 4'h2);
		m2 = mc;
		s(2'h1, 4'h1);
		q_ack.push_back(16'h0007);
		s(2'h2, 4'h0);
		r = xs();
		apb(1'b1, uelm_pkg::REG_MSGSEL, {r[31:4], 4'h2});
		rd(uelm_pkg::REG_MSGDATA, {1'b0, m2[31:0]});
		rd(uelm_pkg::REG_MSGDHI, {9'h000, m2[55:32]});
		`CHK({msg_ready, msg_last}, 5'h12)
		// release the held message, then a disabled block must ignore a new start
		r = xs();
		apb(1'b1, uelm_pkg::REG_CTRL, {r[31:2], 2'h3});
		rd(uelm_pkg::REG_STATUS, 33'h0_0000_0000);
		`CHK(msg_ready, 1'b0)
		apb(1'b1, uelm_pkg::REG_CTRL, 32'h0000_0000);
		s(2'h0, 4'h2);
		rd(uelm_pkg::REG_BITMAP, 33'h0_0000_0007);
		apb(1'b1, uelm_pkg::REG_CTRL, {r[31:2], 2'h1});
		rd(uelm_pkg::REG_CTRL, 33'h0_0000_0001);
		// missing segments resent, final repeated after a lost reply
		s(2'h0, 4'h3);
		q_ack.push_back(16'h0009);
		s(2'h2, 4'h0);
		s(2'h1, 4'h1);
		q_ack.push_back(16'h000f);
		s(2'h2, 4'h2);
		q_ack.push_back(16'h000f);
		s(2'h2, 4'h2);
		s(2'h0, 4'h3);
		s(2'h1, 4'h1);
		s(2'h0, 4'h1);
		q_ack.push_back(16'h0003);
		s(2'h2, 4'h0);
		s(2'h0, 4'hf);
		for (int i = 1; i < 15; i++) s(2'h1, 4'(i));
		q_ack.push_back(16'hffff);
		s(2'h2, 4'h0);
		r = xs();
		i_uelm_gnd.seg({1'b0, r[16:13]}, 2'h2, r[3:0], mc);
		i_uelm_gnd.surv(uelm_pkg::PC_UCLOSE, r[6:4], 3'h0, r[8:7], r[12:9]);
		rd(uelm_pkg::REG_BITMAP, 33'h0_0000_0000);
		rsv(4'h6, 4'h6);
		rsv(4'h3, 4'h6);
		cls(4'h3);
		rsv(4'h3, 4'h6);
		cls(4'h6);
		rsv(4'h3, 4'h3);
		// each delivery restarts the inactivity count
		s(2'h0, 4'h3);
		repeat (600) @(posedge pclk);
		s(2'h1, 4'h1);
		repeat (600) @(posedge pclk);
		rd(uelm_pkg::REG_BITMAP, 33'h0_0000_000a);
		repeat (1100) @(posedge pclk);
		rd(uelm_pkg::REG_BITMAP, 33'h0_0000_0000);
		rsv(4'h5, 4'h5);
		repeat (8) @(posedge pclk);
		`CHK(q_ack.size() + q_um.size() + q_rd.size(), 0)
		tally_and_finish();
	end
endmodule : uelm_rx_tb
